// [design/sdil_loader.sv]
// input latches, channel steering, sequencer and dac transfer of the loader
`timescale 1ns/10ps
`include "sdil_params.svh"

module sdil_loader (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire sdil_pkg::sdil_word_t video_data_in,
    input wire logic [`SDIL_ADDR_W-1:0] channel_addr,
    input wire logic sequence_start_or_select,
    input wire logic sequence_descending,
    input wire logic edge_select_rising,
    input wire logic transfer_request,
    input wire logic polarity_invert,
    input wire logic standby,
    output sdil_pkg::sdil_bank_t video_outputs,
    output logic outputs_above_mid,
    output logic sequencing_active
);
    import sdil_pkg::*;

    // ------------------------------------------------------------
    // falling edge capture
    // ------------------------------------------------------------
    sdil_in_t pins;
    sdil_in_t fall_cap_r;
    sdil_in_t fall_cap_nxt;
    sdil_in_t cur;

    assign pins = '{word: video_data_in, addr: channel_addr,
                    sel: sequence_start_or_select, dir: sequence_descending};

    // falling edge copy, only used when edge select is low
    always_comb begin
        fall_cap_nxt = resetn ? pins : '0;
    end

    always_ff @(negedge ref_clk) begin
        fall_cap_r <= fall_cap_nxt;
    end

    // falling-edge words commit at the next rising edge, half a cycle late
    assign cur = edge_select_rising ? pins : fall_cap_r;

    // ------------------------------------------------------------
    // channel steering and sequencer
    // ------------------------------------------------------------
    sdil_seq_t seq_r;
    sdil_seq_t seq_nxt;
    logic [`SDIL_ADDR_W-1:0] ptr_r;
    logic [`SDIL_ADDR_W-1:0] ptr_nxt;
    logic dir_r;
    logic dir_nxt;
    sdil_bank_t latch_r;
    sdil_bank_t latch_nxt;
    logic [`SDIL_NUM_CH-1:0] load_sel;

    // one-hot channel pick from a channel number; 6 and 7 pick none
    function automatic logic [`SDIL_NUM_CH-1:0] ch_decode(
        input logic [`SDIL_ADDR_W-1:0] ch
    );
        logic [`SDIL_NUM_CH-1:0] hot;
        hot = '0;
        if (ch <= `SDIL_CH_LAST) begin
            hot[ch] = 1'b1;
        end
        return hot;
    endfunction : ch_decode

    always_comb begin
        seq_nxt = seq_r;
        ptr_nxt = ptr_r;
        dir_nxt = dir_r;
        load_sel = '0;
        if (standby) begin
            load_sel = '0;
        end else begin
            unique case (seq_r)
                SDIL_SEQ_IDLE: begin
                    if (cur.addr == `SDIL_ADDR_SEQ && cur.sel) begin
                        // the start word itself fills the first channel
                        dir_nxt = cur.dir;
                        if (cur.dir) begin
                            load_sel = ch_decode(`SDIL_CH_LAST);
                            ptr_nxt = `SDIL_CH_LAST - 3'h1;
                        end else begin
                            load_sel = ch_decode(`SDIL_CH_FIRST);
                            ptr_nxt = `SDIL_CH_FIRST + 3'h1;
                        end
                        seq_nxt = SDIL_SEQ_RUN;
                    end else if (cur.sel && cur.addr != `SDIL_ADDR_NULL) begin
                        load_sel = ch_decode(cur.addr);
                    end
                end
                SDIL_SEQ_RUN: begin
                    load_sel = ch_decode(ptr_r);
                    if (dir_r) begin
                        ptr_nxt = ptr_r - 3'h1;
                        if (ptr_r == `SDIL_CH_FIRST) begin
                            seq_nxt = SDIL_SEQ_IDLE;
                        end
                    end else begin
                        ptr_nxt = ptr_r + 3'h1;
                        if (ptr_r == `SDIL_CH_LAST) begin
                            seq_nxt = SDIL_SEQ_IDLE;
                        end
                    end
                end
                default: seq_nxt = SDIL_SEQ_IDLE;
            endcase
        end
    end

    // latch writes, one generate lane per channel
    generate
        for (genvar i = 0; i < `SDIL_NUM_CH; i++) begin : g_lane
            always_comb begin
                latch_nxt[i] = load_sel[i] ? cur.word : latch_r[i];
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            seq_r <= SDIL_SEQ_IDLE;
            ptr_r <= `SDIL_CH_FIRST;
            dir_r <= 1'b0;
            latch_r <= '0;
        end else begin
            seq_r <= seq_nxt;
            ptr_r <= ptr_nxt;
            dir_r <= dir_nxt;
            latch_r <= latch_nxt;
        end
    end

    assign sequencing_active = (seq_r == SDIL_SEQ_RUN);

    // ------------------------------------------------------------
    // dac transfer and output side
    // ------------------------------------------------------------
    logic xfer_r;
    logic xfer_nxt;
    logic pol_r;
    logic pol_nxt;
    sdil_bank_t dac_r;
    sdil_bank_t dac_nxt;

    // request and polarity sampled on the rising edge
    always_comb begin
        xfer_nxt = transfer_request && !standby;
        pol_nxt = polarity_invert;
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            xfer_r <= 1'b0;
            pol_r <= 1'b0;
        end else begin
            xfer_r <= xfer_nxt;
            pol_r <= pol_nxt;
        end
    end

    // dacs change on the falling edge so outputs settle before the next capture
    always_comb begin
        if (!resetn) begin
            dac_nxt = '0;
        end else if (xfer_r && !standby) begin
            dac_nxt = latch_r;
        end else begin
            dac_nxt = dac_r;
        end
    end

    always_ff @(negedge ref_clk) begin
        dac_r <= dac_nxt;
    end

    // debiased outputs read zero; dac contents survive standby
    assign video_outputs = standby ? '0 : dac_r;
    assign outputs_above_mid = pol_r && !standby;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_addr_load_ch: assert property (@(posedge ref_clk) disable iff (!resetn)
        (seq_r == SDIL_SEQ_IDLE && !standby && cur.sel && cur.addr == 3'h2)
        |=> latch_r[2] == $past(cur.word))
        else $error("addressed word missed channel 2");

    chk_null_addr_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
        (seq_r == SDIL_SEQ_IDLE && cur.addr == `SDIL_ADDR_NULL)
        |=> latch_r == $past(latch_r))
        else $error("address 110 changed a channel latch");

    chk_seq_up_start: assert property (@(posedge ref_clk) disable iff (!resetn)
        (seq_r == SDIL_SEQ_IDLE && !standby && cur.sel && cur.addr == `SDIL_ADDR_SEQ
         && !cur.dir)
        |=> latch_r[0] == $past(cur.word) && ptr_r == 3'h1 && sequencing_active)
        else $error("ascending sequence did not start at channel 0");

    chk_seq_down_start: assert property (@(posedge ref_clk) disable iff (!resetn)
        (seq_r == SDIL_SEQ_IDLE && !standby && cur.sel && cur.addr == `SDIL_ADDR_SEQ
         && cur.dir)
        |=> latch_r[5] == $past(cur.word) && ptr_r == 3'h4)
        else $error("descending sequence did not start at channel 5");

    chk_seq_stop_last: assert property (@(posedge ref_clk) disable iff (!resetn)
        (sequencing_active && !standby && !dir_r && ptr_r == `SDIL_CH_LAST)
        |=> !sequencing_active && latch_r[5] == $past(cur.word))
        else $error("sequence did not end after channel 5");

    chk_xfer_falling: assert property (@(negedge ref_clk) disable iff (!resetn)
        (xfer_r && !standby) |=> dac_r == $past(latch_r))
        else $error("transfer did not move latches to dacs");

    chk_standby_quiet: assert property (@(posedge ref_clk) disable iff (!resetn)
        standby |=> latch_r == $past(latch_r) && video_outputs == '0 || !standby)
        else $error("activity during standby");

    chk_polarity_follow: assert property (@(posedge ref_clk) disable iff (!resetn)
        (!standby && $stable(standby)) |=> outputs_above_mid == $past(polarity_invert)
        || standby)
        else $error("polarity output did not follow input");

endmodule : sdil_loader

// [design/sdil_params.svh]
// constants for the six-channel dac input loader
`ifndef SDIL_PARAMS_SVH
`define SDIL_PARAMS_SVH

`define SDIL_WORD_W 10
`define SDIL_WORD_MSB 9
`define SDIL_NUM_CH 6
`define SDIL_ADDR_W 3
`define SDIL_ADDR_SEQ 3'h7
`define SDIL_ADDR_NULL 3'h6
`define SDIL_CH_FIRST 3'h0
`define SDIL_CH_LAST 3'h5
`define SDIL_WORD_RST 10'h000

`endif

// [design/sdil_pkg.sv]
// types shared by the six-channel dac input loader
`include "sdil_params.svh"

package sdil_pkg;

    typedef logic [`SDIL_WORD_MSB:0] sdil_word_t;

    typedef sdil_word_t [`SDIL_NUM_CH-1:0] sdil_bank_t;

    // one sampled set of loading inputs
    typedef struct packed {
        sdil_word_t word;
        logic [`SDIL_ADDR_W-1:0] addr;
        logic sel;
        logic dir;
    } sdil_in_t;

    typedef enum logic [1:0] {
        SDIL_SEQ_IDLE = 2'b01,
        SDIL_SEQ_RUN = 2'b10
    } sdil_seq_t;

endpackage : sdil_pkg

// [verification/sdil_ctrl_model.sv]
// display timing controller model: drives one word and its steering per clock
`timescale 1ns/10ps
module sdil_ctrl_model (
    input wire logic ref_clk,
    output sdil_pkg::sdil_in_t ctl
);
    import sdil_pkg::*;

    // steering moves just after the rising edge and holds a whole cycle,
    // so both capture edges see the same steering and, unless spoil_word runs, the same word
    task automatic put(input sdil_in_t v);
        @(posedge ref_clk);
        #1;
        ctl = v;
    endtask : put

    // falling-edge mode: spoil the word once it has been captured, so a loader
    // that takes it at the wrong edge picks up the spoiled copy
    task automatic spoil_word();
        ctl.word = ~ctl.word;
    endtask : spoil_word

    // idle controller until the bench starts
    initial begin
        ctl = '0;
    end
endmodule : sdil_ctrl_model

// [verification/tb_six_channel_dac_input_loader.sv]
// self-checking bench for the six-channel dac input loader
`timescale 1ns/10ps
module tb_six_channel_dac_input_loader;
    import sdil_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic xfer = 1'b0;
    logic pol = 1'b0;
    logic sb_in = 1'b0;
    logic esel = 1'b0;
    sdil_in_t ctl;
    sdil_in_t c = '0;
    sdil_bank_t vout;
    logic above;
    logic seq_on;
    bit cx, cp, cs, ps, sb, run, dsc;
    int ch, cycles, error_cnt, num_checks;
    int lat[6], dac[6];

    sdil_ctrl_model u_ctrl (
        .ref_clk(ref_clk),
        .ctl(ctl)
    );

    sdil_loader DUT (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .video_data_in(ctl.word),
        .channel_addr(ctl.addr),
        .sequence_start_or_select(ctl.sel),
        .sequence_descending(ctl.dir),
        .edge_select_rising(esel),
        .transfer_request(xfer),
        .polarity_invert(pol),
        .standby(sb_in),
        .video_outputs(vout),
        .outputs_above_mid(above),
        .sequencing_active(seq_on)
    );

    // 25 MHz master clock
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    // hang guard: the tests need well under this many cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            complete_run();
        end
    end

    // ----------------------------------------
    // reference model and cycle driver
    // ----------------------------------------
    task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    function automatic sdil_in_t mk(input sdil_word_t w, input logic [2:0] a,
                                    input logic s, input logic d);
        return '{word: w, addr: a, sel: s, dir: d};
    endfunction : mk

    // one rising edge of the loader: sequencer steps and channel latch loads
    task automatic upd();
        bit go;
        go = run || (c.sel && c.addr == 3'h7);
        if (cs) return;
        if (!run && go) begin
            dsc = c.dir;
            ch = dsc ? 5 : 0;
        end
        if (go) begin
            lat[ch] = c.word;
            run = ch != (dsc ? 0 : 5);
            ch += dsc ? -1 : 1;
        end else if (c.sel && c.addr < 3'h6) begin
            lat[c.addr] = c.word;
        end
    endtask : upd

    // standby edges are skipped: forcing may be registered or direct
    task automatic cyc(input sdil_in_t n, input logic x, input logic p, input logic s);
        u_ctrl.put(n);
        upd();
        // the falling-edge transfer sees this edge's load; standby at either edge blocks it
        if (cx && !cs && !s) dac = lat;
        cmp(10'(seq_on), 10'(run));
        if (cs == ps) cmp(10'(above), 10'(cp & ~cs));
        xfer = x;
        pol = p;
        sb_in = s;
        esel = 1'($urandom);
        @(negedge ref_clk);
        #1;
        if (!esel) u_ctrl.spoil_word();
        for (int i = 0; i < 6; i++) begin
            if (s == cs && cs == ps) cmp(vout[i], cs ? 10'h000 : 10'(dac[i]));
        end
        ps = cs;
        c = n;
        cx = x;
        cp = p;
        cs = s;
    endtask : cyc

    task automatic complete_run();
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : complete_run

    // main sequence
    initial begin
        void'($urandom(79450));
        repeat (20) @(posedge ref_clk);
        #1;
        resetn = 1'b1;
        // up then down sequences with stray addresses, each followed by a channel 2 load and a null-address word
        for (int d = 0; d < 2; d++) begin
            cyc(mk(10'($urandom), 3'h7, 1'b1, d[0]), 1'b0, 1'b1, 1'b0);
            repeat (5) cyc(mk(10'($urandom), 3'($urandom), 1'b0, 1'b0), 1'b0, 1'b0, 1'b0);
            cyc(mk(10'($urandom), 3'h2, 1'b1, 1'b0), 1'b1, 1'b0, 1'b0);
            cyc(mk('0, 3'h6, 1'b1, 1'b0), 1'b1, 1'b0, 1'b0);
        end
        $display("test sequences done");
        // random traffic: every address, edge mode, polarity, transfers, standby runs
        for (int k = 0; k < 400; k++) begin
            if ($urandom % 12 == 0) sb = ~sb;
            cyc(mk(10'($urandom), 3'($urandom), $urandom % 3 == 0, 1'($urandom)),
                $urandom % 4 == 0, 1'($urandom), sb);
        end
        $display("test random done");
        complete_run();
    end
endmodule : tb_six_channel_dac_input_loader
